// ===== rtl/peripheral_irq_enable_flags.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_enable_flags (
  input wire logic clk,
  input wire logic reset_n,
  input wire irq_pkg::avl_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire irq_pkg::periph_events_t events,
  input wire logic [7:0] core_irq_control,
  output logic [7:0] pending,
  output logic peripheral_irq_req
);
  import irq_pkg::*;

  main_state_t st_reg;
  main_state_t st_next;

  logic req;
  logic first;
  logic accept;
  logic wr_take;
  logic enable_hit;
  logic flag_hit;
  logic pending_hit;
  logic flag_wr;
  logic [7:0] flags;
  logic [7:0] ev_pulse;
  logic [7:0] ev_level;
  logic [7:0] pend_vec;
  logic pend_any;
  logic group_en;
  logic global_en;

  // Request is held by the master until waitrequest drops
  assign req = avs_req.read | avs_req.write;

  bus_ack u_ack (
    .clk(clk),
    .reset_n(reset_n),
    .req(req),
    .waitrequest(avs_waitrequest),
    .first(first),
    .accept(accept)
  );

  // Address decode; unmapped addresses read zero, writes dropped
  always_comb
  begin
    enable_hit = 1'b0;
    flag_hit = 1'b0;
    pending_hit = 1'b0;
    if (avs_req.address == ENABLE_OFS)
      enable_hit = 1'b1;
    else if (avs_req.address == FLAG_OFS)
      flag_hit = 1'b1;
    else if (avs_req.address == PENDING_OFS)
      pending_hit = 1'b1;
  end

  // Writes land only on the accept edge, low byte lane only
  assign wr_take = accept & avs_req.write & avs_req.byteenable[0];
  assign flag_wr = wr_take & flag_hit;

  // sources placed in documented bit order
  always_comb
  begin
    ev_pulse = 8'h00;
    ev_level = 8'h00;
    ev_pulse[BIT_PARPORT] = events.parallel_port_access;
    ev_pulse[BIT_CONVERTER] = events.converter_done;
    ev_pulse[BIT_SYNC_SERIAL] = events.sync_serial_event;
    ev_pulse[BIT_CAPCOMP1] = events.capcomp1_event;
    ev_pulse[BIT_TIMER_B] = events.timer_b_match;
    ev_pulse[BIT_TIMER_A] = events.timer_a_overflow;
    ev_level[BIT_SERIAL_RX] = events.rx_buffer_full;
    ev_level[BIT_SERIAL_TX] = events.tx_buffer_empty;
  end

  // parallel port flag is sticky until software clears it
  flag_bank #(
    .N(N_SRC),
    .RO_MASK(FLAG_RO_MASK),
    .RST(FLAG_RST)
  ) u_flags (
    .clk(clk),
    .reset_n(reset_n),
    .set_pulse(ev_pulse),
    .level_in(ev_level),
    .wr_en(flag_wr),
    .wr_data(avs_req.writedata[7:0]),
    .flags(flags)
  );

  // flag AND enable per source, then gated
  assign pend_vec = flags & st_reg.enable;
  assign pend_any = |pend_vec;
  assign group_en = core_irq_control[GROUP_EN_BIT];
  assign global_en = core_irq_control[GLOBAL_EN_BIT];

  // Next state; read data captured in the wait cycle so it is
  // stable from a flop at the accept edge
  always_comb
  begin
    st_next = st_reg;
    if (wr_take && enable_hit)
      st_next.enable = avs_req.writedata[7:0];
    if (first && avs_req.read)
    begin
      st_next.readdata = 32'h0000_0000;
      if (enable_hit)
        st_next.readdata[7:0] = st_reg.enable;
      else if (flag_hit)
        st_next.readdata[7:0] = flags;
      else if (pending_hit)
        st_next.readdata[7:0] = pend_vec;
    end
    st_next.irq = pend_any & group_en & global_en;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg.enable <= ENABLE_RST;
      st_reg.readdata <= 32'h0000_0000;
      st_reg.irq <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // Read data and request straight from flops; pending is the combinational read-back view
  assign avs_readdata = st_reg.readdata;
  assign peripheral_irq_req = st_reg.irq;
  assign pending = pend_vec;

  // Helper copies for multi-cycle checks
  logic [7:0] wdata_q;
  logic en_wr_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdata_q <= 8'h00;
      en_wr_q <= 1'b0;
    end
    else
    begin
      wdata_q <= avs_req.writedata[7:0];
      en_wr_q <= wr_take & enable_hit;
    end
  end

  a_enable_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    en_wr_q |-> st_reg.enable == wdata_q)
    else $error("enable write not stored");

  a_enable_reads: assert property (
    @(posedge clk) disable iff (!reset_n)
    first && avs_req.read && enable_hit
    ##1 accept |-> avs_readdata[7:0] == st_reg.enable
      || $past(en_wr_q))
    else $error("enable read-back wrong");

  a_group_block: assert property (
    @(posedge clk) disable iff (!reset_n)
    !group_en |=> !peripheral_irq_req)
    else $error("request passed with group enable low");

  a_group_pass: assert property (
    @(posedge clk) disable iff (!reset_n)
    pend_any && group_en && global_en |=> peripheral_irq_req)
    else $error("unmasked request blocked");

  a_irq_cause: assert property (
    @(posedge clk) disable iff (!reset_n)
    peripheral_irq_req |-> $past(pend_any) && $past(group_en)
      && $past(global_en))
    else $error("request without enabled flag");

  a_rx_follow: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 flags[BIT_SERIAL_RX] == $past(events.rx_buffer_full))
    else $error("receive flag not following buffer");

  a_tx_follow: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 flags[BIT_SERIAL_TX] == $past(events.tx_buffer_empty))
    else $error("transmit flag not following buffer");

  a_ro_ignore: assert property (
    @(posedge clk) disable iff (!reset_n)
    flag_wr |=> flags[BIT_SERIAL_RX] == $past(events.rx_buffer_full))
    else $error("read-only flag took a write");

  a_parport_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    flags[BIT_PARPORT] && !flag_wr |=> flags[BIT_PARPORT])
    else $error("parallel port flag dropped by itself");

  a_one_wait: assert property (
    @(posedge clk) disable iff (!reset_n)
    req && avs_waitrequest ##1 req |-> !avs_waitrequest)
    else $error("more than one wait state");

  // Register bus and gating checks; reads compare with the wait cycle
  a_enable_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(wr_take && enable_hit) |=> st_reg.enable == $past(st_reg.enable))
    else $error("enable changed without a write");

  a_flag_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    flag_wr |=> (flags & ~FLAG_RO_MASK) ==
      (($past(avs_req.writedata[7:0]) | $past(ev_pulse)) & ~FLAG_RO_MASK))
    else $error("writable flags did not take the write");

  a_tx_ro_ignore: assert property (
    @(posedge clk) disable iff (!reset_n)
    flag_wr |=> flags[BIT_SERIAL_TX] == $past(events.tx_buffer_empty))
    else $error("transmit flag took a write");

  a_flag_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    first && avs_req.read && flag_hit
      |=> avs_readdata[7:0] == $past(flags))
    else $error("flag read-back wrong");

  a_pending_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    first && avs_req.read && pending_hit
      |=> avs_readdata[7:0] == $past(pend_vec))
    else $error("pending read-back wrong");

  a_global_block: assert property (
    @(posedge clk) disable iff (!reset_n)
    !global_en |=> !peripheral_irq_req)
    else $error("request passed with global enable low");

  a_first_waits: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(req) |-> avs_waitrequest)
    else $error("request accepted without a wait state");

  a_upper_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
endmodule : peripheral_irq_enable_flags
`default_nettype wire

// ===== rtl/irq_pkg.sv
// Contract
// - Eight enable bits, one per peripheral source; 1 enables, 0 masks.
// - Enable register at 0x8c, all bits read/write, cleared at reset.
// - Bit order 7..0: parport, converter, rx, tx, sync, ccp1, tmrb, tmra.
// - Nothing reaches the core unless the group enable bit 6 is set.
// - Flags latch events whatever the enables and global enable say.
// - Flags 5 and 4 are read-only; the other six read/write; reset 0.
// - Group enable 1 passes unmasked requests; 0 blocks them all.
// - Parallel port flag sets on each port access, holds until cleared.
// - Receive flag is 1 while receive buffer is full, 0 when empty.
// - Transmit flag is 1 while transmit buffer is empty, 0 when full.
package irq_pkg;
  localparam int N_SRC = 8;
  // Register byte addresses on the bus
  localparam logic [7:0] ENABLE_OFS = 8'h8c;
  localparam logic [7:0] FLAG_OFS = 8'h90;
  localparam logic [7:0] PENDING_OFS = 8'h94;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  // Source bit positions, shared by enable and flag registers
  localparam int BIT_PARPORT = 7;
  localparam int BIT_CONVERTER = 6;
  localparam int BIT_SERIAL_RX = 5;
  localparam int BIT_SERIAL_TX = 4;
  localparam int BIT_SYNC_SERIAL = 3;
  localparam int BIT_CAPCOMP1 = 2;
  localparam int BIT_TIMER_B = 1;
  localparam int BIT_TIMER_A = 0;
  // Flags that mirror buffer state and ignore writes
  localparam logic [7:0] FLAG_RO_MASK = 8'h30;
  // Positions inside the core interrupt control register
  localparam int GROUP_EN_BIT = 6;
  localparam int GLOBAL_EN_BIT = 7;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avl_req_t;

  typedef struct packed {
    logic parallel_port_access;
    logic converter_done;
    logic rx_buffer_full;
    logic tx_buffer_empty;
    logic sync_serial_event;
    logic capcomp1_event;
    logic timer_b_match;
    logic timer_a_overflow;
  } periph_events_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [31:0] readdata;
    logic irq;
  } main_state_t;
endpackage : irq_pkg

// ===== rtl/bus_ack.sv
`timescale 1ns/1ps
`default_nettype none
module bus_ack (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req,
  output logic waitrequest,
  output logic first,
  output logic accept
);
  typedef struct packed {
    logic ack;
  } ack_state_t;

  ack_state_t st_reg;
  ack_state_t st_next;

  // One wait state lets read data come from a flop at the accept edge
  always_comb
  begin
    st_next.ack = req & ~st_reg.ack;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Handshake outputs are combinational from the held request
  assign waitrequest = req & ~st_reg.ack;
  assign first = req & ~st_reg.ack;
  assign accept = req & st_reg.ack;
endmodule : bus_ack
`default_nettype wire

// ===== rtl/flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
  parameter int N = 8,
  parameter logic [N-1:0] RO_MASK = '0,
  parameter logic [N-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N-1:0] set_pulse,
  input wire logic [N-1:0] level_in,
  input wire logic wr_en,
  input wire logic [N-1:0] wr_data,
  output logic [N-1:0] flags
);
  typedef struct packed {
    logic [N-1:0] flags;
  } bank_state_t;

  bank_state_t st_reg;
  bank_state_t st_next;
  logic [N-1:0] bit_next;

  if (N < 1 || N > 8)
  begin : g_chk
    $error("flag_bank: N must be 1 to 8");
  end

  // Per-bit update; an event in the clearing cycle still wins
  for (genvar i = 0; i < N; i++)
  begin : g_bit
    assign bit_next[i] = RO_MASK[i] ? level_in[i] :
                         set_pulse[i] ? 1'b1 :
                         wr_en ? wr_data[i] : st_reg.flags[i];
  end

  always_comb
  begin
    st_next.flags = bit_next;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_reg.flags <= RST;
    else
      st_reg <= st_next;
  end

  assign flags = st_reg.flags;

  for (genvar i = 0; i < N; i++)
  begin : g_chk_bit
    if (!RO_MASK[i])
    begin : g_sticky
      a_event_sets: assert property (
        @(posedge clk) disable iff (!reset_n)
        set_pulse[i] |=> flags[i])
        else $error("flag missed its event");
    end
  end
endmodule : flag_bank
`default_nettype wire

// ===== test/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// Peripheral event sources plus the core's copy of its control register
module periph_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] fire,
  input wire logic rx_full,
  input wire logic tx_empty,
  input wire logic [7:0] ctrl_in,
  output var irq_pkg::periph_events_t events,
  output logic [7:0] core_irq_control
);
  import irq_pkg::*;

  // pulses last one cycle, buffer states are steady levels
  // this variant has the port, so enable bit 7 may be used
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      events <= '0;
      core_irq_control <= '0;
    end
    else
    begin
      events <= {fire[7:6], rx_full, tx_empty, fire[3:0]};
      core_irq_control <= ctrl_in; // Registered, as the core would hold it
    end
  end
endmodule : periph_model
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb;
  import irq_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  avl_req_t req = '0;
  logic [7:0] fire = '0;
  logic [7:0] ctrl = '0;
  logic rx = 1'b0;
  logic tx = 1'b0;
  logic [31:0] rdata;
  logic wreq;
  logic [7:0] pend;
  logic irq;
  periph_events_t ev;
  logic [7:0] cic;
  logic [31:0] q;
  logic [3:0] be = 4'hf;
  int err_count = 0;
  int n_tests = 0;

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  peripheral_irq_enable_flags i_dut (.clk(clk), .reset_n(reset_n),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .events(ev), .core_irq_control(cic), .pending(pend),
    .peripheral_irq_req(irq));
  periph_model i_model (.clk(clk), .reset_n(reset_n), .fire(fire),
    .rx_full(rx), .tx_empty(tx), .ctrl_in(ctrl), .events(ev),
    .core_irq_control(cic));

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Request held until the rising edge that samples waitrequest low
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d},
             byteenable: be};
    do
    begin
      @(posedge clk);
      i++;
    end
    while (wreq !== 1'b0 && i < 20);
    // Read data stands at the accept edge; release only after it
    q = rdata;
    req <= '0;
    if (i >= 20)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask : rd

  // One-cycle event request, then let it reach the flags
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    fire <= v;
    @(posedge clk);
    fire <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(ENABLE_OFS, ENABLE_RST);
    rd(FLAG_OFS, FLAG_RST);
    $display("test reset done");
    xfer(1'b1, ENABLE_OFS, 8'ha5);
    rd(ENABLE_OFS, 8'ha5);
    xfer(1'b1, ENABLE_OFS, 8'h5a);
    rd(ENABLE_OFS, 8'h5a);
    xfer(1'b1, 8'h00, 8'hff);
    rd(8'h00, 8'h00);
    rd(ENABLE_OFS, 8'h5a);
    xfer(1'b1, ENABLE_OFS, 8'h00);
    xfer(1'b1, FLAG_OFS, 8'hff);
    rd(FLAG_OFS, 8'hff & ~FLAG_RO_MASK);
    xfer(1'b1, FLAG_OFS, 8'h00);
    $display("test access done");
    // Levels pass the model register, then the flag: let them settle
    @(posedge clk);
    rx <= 1'b1;
    tx <= 1'b1;
    repeat (3) @(posedge clk);
    rd(FLAG_OFS, 8'h30);
    xfer(1'b1, FLAG_OFS, 8'h00);
    rd(FLAG_OFS, 8'h30);
    rx <= 1'b0;
    repeat (3) @(posedge clk);
    rd(FLAG_OFS, 8'h10);
    tx <= 1'b0;
    repeat (3) @(posedge clk);
    rd(FLAG_OFS, 8'h00);
    $display("test buffers done");
    // Each of the six sticky event sources latches while masked and globally off
    for (int b = 0; b < 8; b++)
    begin
      if (!FLAG_RO_MASK[b])
      begin
        pulse(8'h01 << b);
        rd(FLAG_OFS, 8'h01 << b);
        rd(FLAG_OFS, 8'h01 << b);
        xfer(1'b1, FLAG_OFS, 8'h00);
      end
    end
    $display("test events done");
    pulse(8'h01);
    xfer(1'b1, ENABLE_OFS, 8'h02);
    ctrl <= 8'hc0;
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    xfer(1'b1, ENABLE_OFS, 8'h01);
    rd(PENDING_OFS, 8'h01);
    // Group and global enable in all four combinations
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      ctrl <= {k[1:0], 6'h00};
      repeat (3) @(negedge clk);
      `CHK(irq, k == 3)
      `CHK(pend, 8'h01)
    end
    xfer(1'b1, FLAG_OFS, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    // Software order: clear a stale flag, then enable its source
    xfer(1'b1, ENABLE_OFS, 8'h00);
    pulse(8'h02);
    xfer(1'b1, FLAG_OFS, 8'h00);
    xfer(1'b1, ENABLE_OFS, 8'h02);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    pulse(8'h02);
    @(negedge clk);
    `CHK(irq, 1'b1)
    $display("test gating done");
    // A write without the low byte lane must not land
    xfer(1'b1, FLAG_OFS, 8'h00);
    be = 4'he;
    xfer(1'b1, ENABLE_OFS, 8'h7e);
    be = 4'hf;
    rd(ENABLE_OFS, 8'h02);
    // Reset in mid-run clears both registers and the request
    xfer(1'b1, ENABLE_OFS, 8'hff);
    xfer(1'b1, FLAG_OFS, 8'hff);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(ENABLE_OFS, ENABLE_RST);
    rd(FLAG_OFS, FLAG_RST);
    `CHK(irq, 1'b0)
    $display("test reset again done");
    tally_and_finish();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
